// ---- rtl/reset_nmi_pin_control.sv ----
// Reset input, reset indication, NMI edge and power-down gating with AXI4-Lite registers
//
// Function
// - Low reset pin with oscillator running resets.
// - Filter drops short lows, passes long lows.
// - Bidirectional mode drives reset pin low during sequence.
// - Reset indication low during any reset.
// - Reset indication stays low until end-of-init.
// - NMI falling edge outside core reset requests NMI trap.
// - Power-down entered only with NMI low.
// - Power-down ignored while NMI high.
// - Bidirectional bit locked after end-of-init, reset clears.
// - Bidirectional mode stretches short reset, reports long.
// - NMI trap number 02, vector 0008; resets 00. Here trap_number stays 02 and the vector 0008 at all times, also during reset.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`include "reset_nmi_defines.svh"
module reset_nmi_pin_control (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Reset pin, open drain
    input wire logic reset_in_pin,
    output logic reset_in_pin_out,
    output logic reset_in_pin_oe,
    // Other pins
    output logic reset_indication_out,
    input wire logic nmi_pin,
    input wire logic osc_watchdog_enable_pin,
    input wire logic osc_running,
    // Core side
    output logic core_reset,
    output logic power_down,
    output logic osc_watchdog_en,
    output logic nmi_trap_req,
    output logic [7:0] trap_number,
    output logic [23:0] nmi_trap_vector,
    output logic irq
);
    import reset_nmi_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        seq_state_t seq;
        reset_cause_t cause;
        logic [7:0] seq_count;
        logic bidir_reset_enable;
        logic init_done;
        logic long_hw;
        logic power_down;
        logic nmi_prev;
        logic nmi_pend;
        logic owd_en;
        logic pin_oe;
        logic ind;
        logic core_reset;
        logic [`IRQ_WIDTH-1:0] irq_status;
        logic [`IRQ_WIDTH-1:0] irq_mask;
        logic irq;
    } ctl_state_t;

    ctl_state_t s;
    ctl_state_t next_s;
    logic rst_sync;
    logic rst_level;
    logic nmi_level;
    logic owe_level;
    logic osc_level;

    pin_sync u_rst_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(reset_in_pin),
        .level(rst_sync)
    );
    spike_filter u_rst_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .level_in(rst_sync),
        .level_out(rst_level)
    );
    pin_sync u_nmi_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(nmi_pin),
        .level(nmi_level)
    );
    pin_sync u_owe_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(osc_watchdog_enable_pin),
        .level(owe_level)
    );
    pin_sync u_osc_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(osc_running),
        .level(osc_level)
    );

    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] wr_val;
    logic ev_sw;
    logic ev_wdt;
    logic ev_end_of_init_instr;
    logic ev_power_down_instr;
    logic ev_ack;
    logic hw_req;
    logic [`IRQ_WIDTH-1:0] irq_set;
    logic [31:0] status_word;

    always_comb begin
        next_s = s;
        wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
        wr_val = s.wdata & wmask;
        wr_fire = s.aw_got && s.w_got && !s.bvalid;
        ev_sw = 1'b0;
        ev_wdt = 1'b0;
        ev_end_of_init_instr = 1'b0;
        ev_power_down_instr = 1'b0;
        ev_ack = 1'b0;
        irq_set = '0;
        hw_req = !rst_level && osc_level;

        // Write channel capture, either order
        next_s.awready = !s.aw_got && !s.bvalid;
        next_s.wready = !s.w_got && !s.bvalid;
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr;
            next_s.awready = 1'b0;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
            next_s.wready = 1'b0;
        end
        if (wr_fire) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `RESP_OKAY;
            unique case ({s.awaddr[7:2], 2'b00})
                `ADDR_CTRL: begin
                    // Lock after end-of-init
                    if (!s.init_done && s.wstrb[0]) begin
                        next_s.bidir_reset_enable = s.wdata[`CTRL_BIDIR_BIT];
                    end
                    ev_sw = wr_val[`CTRL_SWRST_BIT];
                    ev_wdt = wr_val[`CTRL_WDTRST_BIT];
                    ev_end_of_init_instr = wr_val[`CTRL_END_OF_INIT_INSTR_BIT];
                    ev_power_down_instr = wr_val[`CTRL_POWER_DOWN_INSTR_BIT];
                    ev_ack = wr_val[`CTRL_NMIACK_BIT];
                end
                `ADDR_STATUS: ;
                `ADDR_IRQ_STATUS: next_s.irq_status = s.irq_status & ~wr_val[`IRQ_WIDTH-1:0];
                `ADDR_IRQ_MASK: begin
                    if (s.wstrb[0]) begin
                        next_s.irq_mask = s.wdata[`IRQ_WIDTH-1:0];
                    end
                end
                default: next_s.bresp = `RESP_SLVERR;
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Reset sequencer
        unique case (s.seq)
            // A new cause restarts the sequence, even before end-of-init
            seq_idle, seq_wait_end_of_init_instr: begin
                if (hw_req || ev_sw || ev_wdt) begin
                    next_s.seq = seq_run;
                    next_s.seq_count = 8'h00;
                    next_s.cause = hw_req ? cause_hw : (ev_sw ? cause_sw : cause_wdt);
                    next_s.pin_oe = s.bidir_reset_enable;
                    next_s.long_hw = s.bidir_reset_enable;
                    next_s.ind = 1'b0;
                    next_s.core_reset = 1'b1;
                    next_s.init_done = 1'b0;
                    next_s.power_down = 1'b0;
                    if (hw_req) begin
                        irq_set[`IRQ_HWRST_BIT] = 1'b1;
                    end
                end else if (s.seq == seq_wait_end_of_init_instr && ev_end_of_init_instr) begin
                    next_s.seq = seq_idle;
                    next_s.ind = 1'b1;
                    next_s.init_done = 1'b1;
                end
            end
            seq_run: begin
                // Full length runs even if the pin rises early
                if (s.seq_count < 8'(`RESET_SEQ_CYC - 1)) begin
                    next_s.seq_count = s.seq_count + 8'h01;
                end else if (s.pin_oe) begin
                    // Own drive ends first, so its echo through the filter is not a new reset
                    next_s.pin_oe = 1'b0;
                end else if (!hw_req) begin
                    next_s.seq = seq_wait_end_of_init_instr;
                    next_s.core_reset = 1'b0;
                    next_s.bidir_reset_enable = 1'b0;
                end
            end
            default: next_s.seq = seq_idle;
        endcase

        // Power-down gated on NMI level
        if (ev_power_down_instr && s.seq == seq_idle) begin
            if (!nmi_level) begin
                next_s.power_down = 1'b1;
                irq_set[`IRQ_POWER_DOWN_INSTR_BIT] = 1'b1;
            end else begin
                irq_set[`IRQ_POWER_DOWN_INSTR_IGN_BIT] = 1'b1;
            end
        end

        // NMI falling edge, pending until ack; set wins
        next_s.nmi_prev = nmi_level;
        if (ev_ack) begin
            next_s.nmi_pend = 1'b0;
        end
        if (s.nmi_prev && !nmi_level && !s.core_reset) begin
            next_s.nmi_pend = 1'b1;
            next_s.power_down = 1'b0;
            irq_set[`IRQ_NMI_BIT] = 1'b1;
        end

        next_s.owd_en = owe_level;
        next_s.irq_status = next_s.irq_status | irq_set;
        next_s.irq = |(next_s.irq_status & s.irq_mask);

        // Read channel
        status_word = '0;
        status_word[`ST_IN_RESET_BIT] = s.core_reset;
        status_word[`ST_INIT_DONE_BIT] = s.init_done;
        status_word[`ST_POWER_DOWN_BIT] = s.power_down;
        status_word[`ST_NMI_PEND_BIT] = s.nmi_pend;
        status_word[`ST_OWD_EN_BIT] = s.owd_en;
        status_word[`ST_LONG_HW_BIT] = s.long_hw;
        status_word[`ST_BIDIR_BIT] = s.bidir_reset_enable;
        next_s.arready = !s.rvalid && !s.arready;
        if (s_axi_arvalid && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = `RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `ADDR_CTRL: next_s.rdata = {31'h0, s.bidir_reset_enable};
                `ADDR_STATUS: next_s.rdata = status_word;
                `ADDR_IRQ_STATUS: next_s.rdata = {28'h0, s.irq_status};
                `ADDR_IRQ_MASK: next_s.rdata = {28'h0, s.irq_mask};
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.ind <= 1'b0;
            s.owd_en <= 1'b1;
            s.nmi_prev <= 1'b1;
            s.core_reset <= 1'b1;
            // Power-on runs the full sequence, or the core would stay in reset
            s.seq <= seq_run;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign reset_in_pin_out = 1'b0;
    assign reset_in_pin_oe = s.pin_oe;
    assign reset_indication_out = s.ind;
    assign core_reset = s.core_reset;
    assign power_down = s.power_down;
    assign osc_watchdog_en = s.owd_en;
    assign nmi_trap_req = s.nmi_pend;
    // Fixed trap codes
    assign trap_number = `NMI_TRAP_NUMBER;
    assign nmi_trap_vector = `NMI_TRAP_VECTOR;
    assign irq = s.irq;
endmodule : reset_nmi_pin_control

// ---- rtl/reset_nmi_defines.svh ----
// Offsets, field positions, reset values and timing counts for the reset and NMI pin block
`ifndef RESET_NMI_DEFINES_SVH
`define RESET_NMI_DEFINES_SVH

`define CLK_PERIOD_NS 100
`define SPIKE_MIN_NS 10
`define SPIKE_PASS_NS 100
// Longest ignored pulse rounds down, but never below one cycle
`define SPIKE_MIN_CYC ((`SPIKE_MIN_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`SPIKE_MIN_NS / `CLK_PERIOD_NS))
// Passed pulse rounds up
`define SPIKE_PASS_CYC ((`SPIKE_PASS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_SEQ_CYC 16

`define NMI_TRAP_NUMBER 8'h02
`define NMI_TRAP_VECTOR 24'h000008
`define RESET_TRAP_NUMBER 8'h00
`define RESET_TRAP_VECTOR 24'h000000

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0c

`define CTRL_BIDIR_BIT 0
`define CTRL_SWRST_BIT 1
`define CTRL_WDTRST_BIT 2
`define CTRL_END_OF_INIT_INSTR_BIT 3
`define CTRL_POWER_DOWN_INSTR_BIT 4
`define CTRL_NMIACK_BIT 5

`define ST_IN_RESET_BIT 0
`define ST_INIT_DONE_BIT 1
`define ST_POWER_DOWN_BIT 2
`define ST_NMI_PEND_BIT 3
`define ST_OWD_EN_BIT 4
`define ST_LONG_HW_BIT 5
`define ST_BIDIR_BIT 6

`define IRQ_NMI_BIT 0
`define IRQ_HWRST_BIT 1
`define IRQ_POWER_DOWN_INSTR_BIT 2
`define IRQ_POWER_DOWN_INSTR_IGN_BIT 3
`define IRQ_WIDTH 4

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- rtl/reset_nmi_pkg.sv ----
// Types shared by the reset and NMI pin block
package reset_nmi_pkg;
    typedef enum logic [1:0] {
        seq_idle,
        seq_run,
        seq_wait_end_of_init_instr
    } seq_state_t;

    typedef enum logic [1:0] {
        cause_none,
        cause_hw,
        cause_sw,
        cause_wdt
    } reset_cause_t;
endpackage : reset_nmi_pkg

// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ns
module pin_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pin
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.stage = {s.stage[1:0], pin};
        if (s.stage[1] == s.stage[2]) begin
            next_s.level = s.stage[2];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{stage: 3'h7, level: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;
endmodule : pin_sync

// ---- rtl/spike_filter.sv ----
// Low-pulse filter: a low no longer than the pass count is dropped
`timescale 1ns/1ns
`include "reset_nmi_defines.svh"
module spike_filter (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Synchronised level in, filtered level out
    input wire logic level_in,
    output logic level_out
);
    typedef struct packed {
        logic [7:0] low_count;
        logic level;
    } filt_state_t;

    filt_state_t s;
    filt_state_t next_s;

    always_comb begin
        next_s = s;
        if (level_in) begin
            next_s.low_count = 8'h00;
            next_s.level = 1'b1;
        end else if (s.low_count < 8'(`SPIKE_PASS_CYC)) begin
            next_s.low_count = s.low_count + 8'h01;
        end else begin
            next_s.level = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{low_count: 8'h00, level: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign level_out = s.level;
endmodule : spike_filter

// ---- testbench/reset_nmi_pin_control_assertions.sv ----
// Port-level checks for the reset and NMI pin block
`timescale 1ns/1ns
module reset_nmi_checks (
    // Clock, reset and bus activity
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_wvalid,
    // Pins
    input wire logic reset_in_pin,
    input wire logic reset_in_pin_oe,
    input wire logic reset_indication_out,
    input wire logic nmi_pin,
    input wire logic osc_watchdog_enable_pin,
    input wire logic osc_running,
    // Core side
    input wire logic core_reset,
    input wire logic power_down,
    input wire logic osc_watchdog_en,
    input wire logic nmi_trap_req,
    input wire logic [7:0] trap_number,
    input wire logic [23:0] nmi_trap_vector
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_const;
        trap_number == 8'h02 && nmi_trap_vector == 24'h000008;
    endproperty
    a_const: assert property (p_const) else $error("trap constants wrong");
    property p_ind;
        core_reset || reset_in_pin_oe |-> !reset_indication_out;
    endproperty
    a_ind: assert property (p_ind) else $error("indication high in reset");
    property p_rise;
        $rose(reset_indication_out) |-> !core_reset;
    endproperty
    a_rise: assert property (p_rise) else $error("indication released in reset");
    property p_edge;
        $fell(nmi_pin) && !core_reset |-> ##[1:6] nmi_trap_req;
    endproperty
    a_edge: assert property (p_edge) else $error("nmi edge lost");
    // Ack strobe may land two cycles after its data beat
    property p_hold;
        nmi_trap_req && !s_axi_wvalid && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2) |=> nmi_trap_req;
    endproperty
    a_hold: assert property (p_hold) else $error("pending nmi dropped");
    property p_pd;
        $rose(power_down) |-> !nmi_pin;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down with nmi high");
    property p_hw;
        (!reset_in_pin && osc_running && !reset_in_pin_oe) [*8] |-> core_reset;
    endproperty
    a_hw: assert property (p_hw) else $error("reset pin low not taken");
    property p_owd;
        osc_watchdog_enable_pin [*6] |-> osc_watchdog_en;
    endproperty
    a_owd: assert property (p_owd) else $error("watchdog enable not followed");
    c_nmi: cover property ($rose(nmi_trap_req));
    c_pd: cover property ($rose(power_down));
    c_oe: cover property ($rose(reset_in_pin_oe));
endmodule : reset_nmi_checks

bind reset_nmi_pin_control reset_nmi_checks u_checks (.aclk, .aresetn, .s_axi_wvalid, .reset_in_pin,
    .reset_in_pin_oe, .reset_indication_out, .nmi_pin, .osc_watchdog_enable_pin, .osc_running,
    .core_reset, .power_down, .osc_watchdog_en, .nmi_trap_req, .trap_number, .nmi_trap_vector);

// ---- testbench/board_reset_model.sv ----
// Board reset supervisor on the shared open-drain reset line
`timescale 1ns/1ns
module board_reset_model (
    // Clock
    input wire logic aclk,
    // Device drive
    input wire logic reset_in_pin_out,
    input wire logic reset_in_pin_oe,
    // Resolved line
    output logic reset_in_pin
);
    logic pull_low = 1'b0;
    // Pull-up: a released line reads high
    assign reset_in_pin = !(pull_low || (reset_in_pin_oe && !reset_in_pin_out));
    // Hold shortened from the slow board figure to keep runs short
    task hold_low(input int n);
        @(posedge aclk);
        pull_low <= 1'b1;
        repeat (n) @(posedge aclk);
        pull_low <= 1'b0;
    endtask : hold_low
endmodule : board_reset_model

// ---- testbench/tb.sv ----
// Self-checking bench for the reset and NMI pin block
`timescale 1ns/1ns
`include "reset_nmi_defines.svh"
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic nmi_pin = 1'b1, osc_watchdog_enable_pin = 1'b1, osc_running = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic reset_in_pin, reset_in_pin_out, reset_in_pin_oe, reset_indication_out, core_reset;
    logic power_down, osc_watchdog_en, nmi_trap_req, irq;
    logic [7:0] trap_number;
    logic [23:0] nmi_trap_vector;
    int n_errors = 0;
    int n_checks = 0;

    reset_nmi_pin_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .reset_in_pin, .reset_in_pin_out, .reset_in_pin_oe, .reset_indication_out,
        .nmi_pin, .osc_watchdog_enable_pin, .osc_running, .core_reset, .power_down, .osc_watchdog_en,
        .nmi_trap_req, .trap_number, .nmi_trap_vector, .irq);
    board_reset_model board (.aclk, .reset_in_pin_out, .reset_in_pin_oe, .reset_in_pin);

    initial begin
        forever #50 aclk = ~aclk;
    end

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Wait for a level; with hold set, insist it stays for n cycles
    task automatic see(ref logic s, input logic v, input int n, input bit hold = 0);
        for (int k = 0; k < n; k++) begin
            @(posedge aclk);
            if (hold && s !== v) begin
                `CK("held level", v, s)
                return;
            end
            if (!hold && s === v) begin
                n_checks++;
                return;
            end
        end
        if (hold) begin
            n_checks++;
        end else begin
            `CK("level in time", v, s)
            end_of_test();
        end
    endtask : see

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = `RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                `CK("bresp", e, s_axi_bresp)
                return;
            end
        end
        `CK("bvalid", 1'b1, s_axi_bvalid)
        end_of_test();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                `CK("read", e, {s_axi_rresp, s_axi_rdata & m})
                return;
            end
        end
        `CK("rvalid", 1'b1, s_axi_rvalid)
        end_of_test();
    endtask : rd

    task t_start;
        repeat (2) @(posedge aclk);
        `CK("outputs", 5'b10010, {core_reset, reset_indication_out, reset_in_pin_oe, osc_watchdog_en, irq})
        `CK("trap", 32'h02000008, {trap_number, nmi_trap_vector})
        rd(8'h10, 32'hffffffff, {`RESP_SLVERR, 32'h0});
        wr(8'h10, 32'h0, `RESP_SLVERR);
    endtask : t_start

    task t_seq;
        board.hold_low(10);
        see(core_reset, 1'b0, 60);
        see(reset_indication_out, 1'b0, 5, 1);
        wr(`ADDR_CTRL, 32'h01);
        rd(`ADDR_STATUS, 32'h40, {2'b00, 32'h40});
        wr(`ADDR_CTRL, 32'h03);
        see(reset_in_pin_oe, 1'b1, 10);
        see(core_reset, 1'b0, 60);
        rd(`ADDR_STATUS, 32'h60, {2'b00, 32'h20});
        wr(`ADDR_CTRL, 32'h08);
        see(reset_indication_out, 1'b1, 10);
        wr(`ADDR_CTRL, 32'h01);
        rd(`ADDR_STATUS, 32'h40, {2'b00, 32'h00});
        wr(`ADDR_CTRL, 32'h04);
        see(core_reset, 1'b1, 10);
        `CK("indication", 1'b0, reset_indication_out)
        see(core_reset, 1'b0, 60);
        see(reset_indication_out, 1'b0, 5, 1);
        wr(`ADDR_CTRL, 32'h08);
        see(reset_indication_out, 1'b1, 10);
    endtask : t_seq

    task t_filter;
        @(posedge aclk);
        osc_running <= 1'b0;
        fork
            board.hold_low(10);
            see(core_reset, 1'b0, 16, 1);
        join
        @(posedge aclk);
        osc_running <= 1'b1;
        fork
            board.hold_low(1);
            see(core_reset, 1'b0, 10, 1);
        join
        board.hold_low(8);
        see(core_reset, 1'b1, 10);
        `CK("indication", 1'b0, reset_indication_out)
        see(core_reset, 1'b0, 60);
        rd(`ADDR_IRQ_STATUS, 32'h2, {2'b00, 32'h2});
        wr(`ADDR_CTRL, 32'h08);
        see(reset_indication_out, 1'b1, 10);
    endtask : t_filter

    task t_nmi;
        wr(`ADDR_IRQ_STATUS, 32'h0f);
        wr(`ADDR_IRQ_MASK, 32'h01);
        @(posedge aclk);
        nmi_pin <= 1'b0;
        see(nmi_trap_req, 1'b1, 10);
        see(irq, 1'b1, 5);
        rd(`ADDR_STATUS, 32'h08, {2'b00, 32'h08});
        wr(`ADDR_CTRL, 32'h20);
        repeat (2) @(posedge aclk);
        see(nmi_trap_req, 1'b0, 8, 1);
        wr(`ADDR_IRQ_STATUS, 32'h01);
        see(irq, 1'b0, 5);
        wr(`ADDR_IRQ_MASK, 32'h00);
        @(posedge aclk);
        nmi_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        nmi_pin <= 1'b0;
        see(nmi_trap_req, 1'b1, 10);
        see(irq, 1'b0, 5, 1);
        rd(`ADDR_IRQ_STATUS, 32'h1, {2'b00, 32'h1});
        wr(`ADDR_CTRL, 32'h20);
        wr(`ADDR_IRQ_STATUS, 32'h01);
    endtask : t_nmi

    task t_power;
        wr(`ADDR_CTRL, 32'h10);
        see(power_down, 1'b1, 10);
        @(posedge aclk);
        nmi_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        nmi_pin <= 1'b0;
        see(power_down, 1'b0, 10);
        wr(`ADDR_CTRL, 32'h20);
        @(posedge aclk);
        nmi_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        wr(`ADDR_CTRL, 32'h10);
        see(power_down, 1'b0, 12, 1);
        rd(`ADDR_IRQ_STATUS, 32'hc, {2'b00, 32'hc});
        @(posedge aclk);
        osc_watchdog_enable_pin <= 1'b0;
        see(osc_watchdog_en, 1'b0, 8);
        @(posedge aclk);
        osc_watchdog_enable_pin <= 1'b1;
        see(osc_watchdog_en, 1'b1, 8);
    endtask : t_power

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_start();
        t_seq();
        t_filter();
        t_nmi();
        t_power();
        end_of_test();
    end
endmodule : tb
